// [verification/pix_capture.sv]
`timescale 1ns/10ps
`default_nettype none

module pix_capture (
    // clock
    input  wire logic                sys_clk,
    // lines from the formatter
    input  wire pixel_out_pkg::rgb_t portA,
    input  wire pixel_out_pkg::rgb_t portB,
    input  wire logic                portAOe,
    input  wire logic                portBOe,
    input  wire logic                strobe,
    input  wire logic                strobeOe,
    input  wire logic                lineSync,
    input  wire logic                lineSyncOe,
    // captured word
    output logic                     got,
    output logic [48:0]              word
);
    import pixel_out_pkg::*;
    logic prevStrobe = 1'b0;

    // released data lines show the inverse of what was last driven
    always @(posedge sys_clk) begin
        got <= strobeOe && strobe && !prevStrobe;
        word <= {lineSyncOe ? lineSync : ~lineSync,
                 portAOe ? portA : ~portA,
                 portBOe ? portB : ~portB};
        prevStrobe <= strobe;
    end
endmodule : pix_capture

`default_nettype wire

// [verification/pix_out_chk.sv]
`timescale 1ns/10ps
`default_nettype none

module pix_out_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // inputs seen
    input wire logic pixClk,
    input wire logic outputSplitSelect,
    input wire logic lowPowerPinN,
    input wire logic greenSyncSliceIn,
    // outputs seen
    input wire logic portAOe,
    input wire logic portBOe,
    input wire logic strobeOe,
    input wire logic lineSyncOe,
    input wire logic outputStrobeClock,
    input wire logic outputStrobeClockN,
    input wire logic greenSyncSliceOut
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_single;
        (!outputSplitSelect && lowPowerPinN) [*8];
    endsequence
    sequence s_dual;
        (outputSplitSelect && lowPowerPinN) [*8];
    endsequence

    a_strobe_pair: assert property (
        outputStrobeClockN != outputStrobeClock) else $error("strobe pair");
    a_power_off: assert property (
        !lowPowerPinN [*4] |-> !(portAOe || portBOe || strobeOe || lineSyncOe))
        else $error("enable high in power-down");
    a_strobe_stop: assert property (
        !lowPowerPinN [*4] |-> !outputStrobeClock) else $error("strobe runs");
    a_portb_single: assert property (
        s_single |-> !portBOe) else $error("port B driven in single mode");
    a_portb_dual: assert property (
        s_dual ##1 s_dual |-> portBOe) else $error("port B idle in dual mode");
    a_green_pass: assert property (
        $stable(greenSyncSliceIn) [*5] |-> greenSyncSliceOut == greenSyncSliceIn)
        else $error("green slice not passed");
    a_single_rate: assert property (
        s_single ##0 $rose(pixClk) |-> ##[3:14] $rose(outputStrobeClock))
        else $error("strobe missed pixel");
    a_dual_half: assert property (
        s_dual ##0 $rose(outputStrobeClock)
        |-> (outputStrobeClock || !lowPowerPinN) [*8])
        else $error("dual strobe too fast");
endmodule : pix_out_chk

bind rgb_pixel_output_formatter pix_out_chk pix_out_chk_i (.sys_clk, .resetn,
    .pixClk, .outputSplitSelect, .lowPowerPinN, .greenSyncSliceIn, .portAOe,
    .portBOe, .strobeOe, .lineSyncOe, .outputStrobeClock, .outputStrobeClockN,
    .greenSyncSliceOut);

`default_nettype wire

// [verification/test_rgb_pixel_output_formatter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pixel_out_params.svh"

module test_rgb_pixel_output_formatter;
    import pixel_out_pkg::*;
    logic                    sys_clk = 1'b0;
    logic                    resetn = 1'b0;
    logic                    pixClk = 1'b0;
    rgb_t                    sampleIn = 24'h000000;
    logic                    lineSyncIn = 1'b0;
    logic                    lineSyncInActiveLow = 1'b0;
    logic                    greenSyncSliceIn = 1'b0;
    logic                    outputSplitSelect = 1'b0;
    logic                    simultaneousOutputSelect = 1'b0;
    logic [`PIX_PHASE_W-1:0] samplePhase = 3'h0;
    logic                    lowPowerPinN = 1'b0;
    wire rgb_t               portA;
    wire rgb_t               portB;
    rgb_t                    heldA;
    logic                    portAOe, portBOe, strobeOe, lineSyncOe, got;
    logic                    pixRun = 1'b0;
    logic [48:0]             nextExp;
    logic                    outputStrobeClock, lineSyncOut, greenSyncSliceOut;
    logic [48:0]             word;
    logic [48:0]             expQ[$];
    integer                  bad_count = 0, samples_checked = 0, cycles = 0;
    integer                  seed = 32'hE38D, idx = 0, prevS = 0, i;

    rgb_pixel_output_formatter rgb_pixel_output_formatter_i (.sys_clk,
        .resetn, .pixClk, .sampleIn, .lineSyncIn, .lineSyncInActiveLow,
        .greenSyncSliceIn, .outputSplitSelect, .simultaneousOutputSelect,
        .samplePhase, .lowPowerPinN, .redA(portA[0]), .greenA(portA[1]),
        .blueA(portA[2]), .redB(portB[0]), .greenB(portB[1]),
        .blueSecondPortData(portB[2]), .portAOe, .portBOe,
        .outputStrobeClock, .outputStrobeClockN(), .strobeOe, .lineSyncOut,
        .lineSyncOe, .greenSyncSliceOut);

    pix_capture pix_capture_i (.sys_clk, .portA, .portB, .portAOe, .portBOe,
        .strobe(outputStrobeClock), .strobeOe, .lineSync(lineSyncOut),
        .lineSyncOe, .got, .word);

    task automatic results();
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    // single mode leaves port B out of the comparison
    task automatic check_cap(input logic [48:0] e, input logic [48:0] g);
        samples_checked++;
        if (outputSplitSelect ? e !== g : e[48:24] !== g[48:24]) begin
            bad_count++;
            $display("CHECK FAILED %0t capture exp %h got %h", $time, e, g);
        end
    endtask : check_cap

    task automatic check_bit(input logic e, input logic g);
        samples_checked++;
        if (e !== g) begin
            bad_count++;
            $display("CHECK FAILED %0t level exp %b got %b", $time, e, g);
        end
    endtask : check_bit

    task automatic pixel(input logic s);
        rgb_t v;
        v = rgb_t'($random(seed));
        sampleIn <= v;
        lineSyncIn <= s ^ lineSyncInActiveLow;
        if (s && !prevS) idx = 0;
        prevS = s;
        if (!outputSplitSelect) expQ.push_back({s, v, 24'h000000});
        else if (idx == 0) begin
            heldA = v;
            idx = 1;
        end else begin
            expQ.push_back({s, heldA, v});
            idx = 0;
        end
    endtask : pixel

    // mode and phase only change while powered down and the pixel clock stands
    task automatic segment(input logic sp, input logic pa, input logic al);
        @(posedge sys_clk);
        lowPowerPinN <= 1'b0;
        outputSplitSelect <= sp;
        simultaneousOutputSelect <= pa;
        lineSyncInActiveLow <= al;
        lineSyncIn <= al;
        samplePhase <= 3'($random(seed));
        greenSyncSliceIn <= ~greenSyncSliceIn;
        repeat (10) @(posedge sys_clk);
        check_bit(greenSyncSliceIn, greenSyncSliceOut);
        lowPowerPinN <= 1'b1;
        repeat (20) @(posedge sys_clk);
        // odd line length leaves one sample without a partner
        // new sample goes out at the first edge after the pixel clock falls
        for (int n = 0; n < 10; n++) begin
            if (n > 0) @(negedge pixClk);
            @(posedge sys_clk);
            pixel(n % 5 < 2);
            pixRun <= 1'b1;
        end
        @(negedge pixClk);
        @(posedge sys_clk);
        pixRun <= 1'b0;
        repeat (30) @(posedge sys_clk);
    endtask : segment

    always #5 sys_clk = ~sys_clk;

    // gated pixel clock of 125 ns, offset so no edge meets a sys_clk edge
    initial begin
        #3.3;
        forever #62.5 if (pixRun || pixClk) pixClk = ~pixClk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (got === 1'b1) begin
            // a capture with nothing expected can never match
            nextExp = 'x;
            if (expQ.size() > 0) nextExp = expQ.pop_front();
            check_cap(nextExp, word);
        end
        if (cycles == 4000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        for (i = 0; i < 6; i++) segment(i > 1, i[0], i[0] ^ i[1]);
        check_bit(1'b1, expQ.size() == 0);
        results();
    end
endmodule : test_rgb_pixel_output_formatter

`default_nettype wire

// [verilog/phase_delay.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pixel_out_params.svh"

module phase_delay (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    // phase select
    input  wire logic [`PIX_PHASE_W-1:0] phase,
    // bundles
    pix_bus_if.dst                       inBus,
    pix_bus_if.src                       outBus
);
    import pixel_out_pkg::*;

    pix_s line_q [`PIX_PHASE_DEPTH];
    pix_s line_d [`PIX_PHASE_DEPTH];
    pix_s out_q;
    pix_s out_d;

    // one tap for the whole bundle keeps data, strobes and sync aligned
    always_comb begin
        line_d[0] = inBus.bundle;
        for (int i = 1; i < `PIX_PHASE_DEPTH; i++) begin
            line_d[i] = line_q[i-1];
        end
        out_d = line_q[phase];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `PIX_PHASE_DEPTH; i++) begin
                line_q[i] <= '0;
            end
            out_q <= '0;
        end else begin
            line_q <= line_d;
            out_q  <= out_d;
        end
    end

    assign outBus.bundle = out_q;

endmodule : phase_delay

`default_nettype wire

// [verilog/pix_bus_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface pix_bus_if;
    import pixel_out_pkg::*;

    pix_s bundle;

    modport src (output bundle);
    modport dst (input bundle);
endinterface : pix_bus_if

`default_nettype wire

// [verilog/pixel_out_params.svh]
`ifndef PIXEL_OUT_PARAMS_SVH
`define PIXEL_OUT_PARAMS_SVH

// sample width and channel count
`define PIX_DATA_W      8
`define PIX_CHANNELS    3
// depth of the common phase delay line and width of its select
`define PIX_PHASE_DEPTH 8
`define PIX_PHASE_W     3
// synchroniser stages ahead of any logic on pin inputs
`define PIX_SYNC_STAGES 2
// output values shown after reset
`define PIX_DATA_RST    8'h00
`define PIX_BIT_RST     1'b0

`endif

// [verilog/pixel_out_pkg.sv]
`include "pixel_out_params.svh"

package pixel_out_pkg;

    typedef logic [`PIX_DATA_W-1:0] sample_t;
    typedef sample_t [`PIX_CHANNELS-1:0] rgb_t;

    // which port the next dual-mode sample goes to
    typedef enum logic [1:0] {
        STEER_A = 2'b01,
        STEER_B = 2'b10
    } steer_e;

    // everything that must move together when the phase changes
    typedef struct packed {
        rgb_t portA;
        rgb_t portB;
        logic strobe;
        logic lineSync;
    } pix_s;

endpackage : pixel_out_pkg

// [verilog/rgb_pixel_output_formatter.sv]
// Function
// - output bit 7 carries the sample MSB, bit 0 the LSB
// - split select 0: all samples on port A, port B tri-stated
// - split select 1: successive pixels alternate between port A and B
// - dual simultaneous: both ports update together every second pixel
// - dual interleaved: one port updates per pixel, alternating
// - steering restarts at line sync: first sample to A, then B
// - pixel-clock-to-output latency grows by one sys_clk cycle for each step of phase
// - phase shift moves data, both strobes and line sync together
// - true and complement strobes are made from the pixel clock
// - single-port mode: strobe frequency equals pixel frequency
// - dual-port mode: strobe and data run at half pixel rate
// - line sync out is always active high
// - line sync is regenerated and aligned with strobes and data
// - green sync slice passes straight through unprocessed
// - green sync slice keeps working in power-down
// - power-down low tri-states outputs and stops the strobe
`timescale 1ns/10ps
`default_nettype none
`include "pixel_out_params.svh"

module rgb_pixel_output_formatter (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    // pixel sampling side, all asynchronous pins
    input  wire logic                    pixClk,
    input  wire pixel_out_pkg::rgb_t     sampleIn,
    input  wire logic                    lineSyncIn,
    input  wire logic                    lineSyncInActiveLow,
    input  wire logic                    greenSyncSliceIn,
    // mode and phase controls
    input  wire logic                    outputSplitSelect,
    input  wire logic                    simultaneousOutputSelect,
    input  wire logic [`PIX_PHASE_W-1:0] samplePhase,
    input  wire logic                    lowPowerPinN,
    // output ports
    output logic [`PIX_DATA_W-1:0]       redA,
    output logic [`PIX_DATA_W-1:0]       greenA,
    output logic [`PIX_DATA_W-1:0]       blueA,
    output logic [`PIX_DATA_W-1:0]       redB,
    output logic [`PIX_DATA_W-1:0]       greenB,
    output logic [`PIX_DATA_W-1:0]       blueSecondPortData,
    output logic                         portAOe,
    output logic                         portBOe,
    // strobe and sync
    output logic                         outputStrobeClock,
    output logic                         outputStrobeClockN,
    output logic                         strobeOe,
    output logic                         lineSyncOut,
    output logic                         lineSyncOe,
    output logic                         greenSyncSliceOut
);
    import pixel_out_pkg::*;

    localparam int SYNC_W = `PIX_DATA_W * `PIX_CHANNELS + 7 + `PIX_PHASE_W;

    // synchronisers: stage 0 is read only by stage 1
    logic [SYNC_W-1:0] syncS0_q;
    logic [SYNC_W-1:0] syncS1_q;
    logic [SYNC_W-1:0] syncIn;
    logic              pixClkLast_q;

    assign syncIn = {pixClk, lineSyncIn, lineSyncInActiveLow,
                     greenSyncSliceIn, outputSplitSelect,
                     simultaneousOutputSelect, lowPowerPinN, samplePhase,
                     sampleIn};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            syncS0_q     <= '0;
            syncS1_q     <= '0;
            pixClkLast_q <= `PIX_BIT_RST;
        end else begin
            syncS0_q     <= syncIn;
            syncS1_q     <= syncS0_q;
            pixClkLast_q <= syncS1_q[SYNC_W-1];
        end
    end

    logic pixClkS;
    logic lineSyncS;
    logic lineSyncPolS;
    logic greenSyncS;
    logic splitS;
    logic simulS;
    logic powerUpS;
    rgb_t sampleS;
    logic pixTick;
    logic [`PIX_PHASE_W-1:0] phaseS;

    assign {pixClkS, lineSyncS, lineSyncPolS, greenSyncS, splitS,
            simulS, powerUpS, phaseS, sampleS} = syncS1_q;
    assign pixTick = pixClkS & ~pixClkLast_q;

    // formatting state
    steer_e steer_q;
    steer_e steer_d;
    rgb_t   holdA_q;
    rgb_t   holdA_d;
    logic   lineHigh_q;
    logic   lineHigh_d;
    pix_s   stage_q;
    pix_s   stage_d;
    logic   lineActive;

    // polarity corrected incoming line sync
    assign lineActive = lineSyncS ^ lineSyncPolS;

    always_comb begin
        steer_d    = steer_q;
        holdA_d    = holdA_q;
        lineHigh_d = lineHigh_q;
        stage_d    = stage_q;
        if (!powerUpS) begin
            stage_d.strobe = 1'b0;
        end else if (!splitS) begin
            stage_d.strobe = pixClkS;
        end
        if (pixTick) begin
            lineHigh_d       = lineActive;
            stage_d.lineSync = lineActive;
            if (!splitS) begin
                stage_d.portA = sampleS;
                steer_d       = STEER_A;
            end else begin
                // rising line sync sends this sample to port A
                if (lineActive && !lineHigh_q) begin
                    steer_d = STEER_A;
                end else begin
                    steer_d = steer_q;
                end
                unique case (steer_d)
                    STEER_A: begin
                        holdA_d = sampleS;
                        if (!simulS) begin
                            stage_d.portA = sampleS;
                        end
                        steer_d = STEER_B;
                        if (powerUpS) begin
                            stage_d.strobe = 1'b0;
                        end
                    end
                    STEER_B: begin
                        stage_d.portB = sampleS;
                        if (simulS) begin
                            stage_d.portA = holdA_q;
                        end
                        steer_d = STEER_A;
                        if (powerUpS) begin
                            stage_d.strobe = 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            steer_q    <= STEER_A;
            holdA_q    <= '0;
            lineHigh_q <= `PIX_BIT_RST;
            stage_q    <= '0;
        end else begin
            steer_q    <= steer_d;
            holdA_q    <= holdA_d;
            lineHigh_q <= lineHigh_d;
            stage_q    <= stage_d;
        end
    end

    // data, strobe and line sync share one delay line so their latency is equal
    pix_bus_if stageBus ();
    pix_bus_if delayedBus ();

    assign stageBus.bundle = stage_q;

    phase_delay phaseDelay (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .phase   (phaseS),
        .inBus   (stageBus),
        .outBus  (delayedBus)
    );

    // output registers
    pix_s dly;
    assign dly = delayedBus.bundle;

    logic [`PIX_DATA_W-1:0] redA_d;
    logic [`PIX_DATA_W-1:0] greenA_d;
    logic [`PIX_DATA_W-1:0] blueA_d;
    logic [`PIX_DATA_W-1:0] redB_d;
    logic [`PIX_DATA_W-1:0] greenB_d;
    logic [`PIX_DATA_W-1:0] blueB_d;
    logic                   portAOe_d;
    logic                   portBOe_d;
    logic                   strobe_d;

    always_comb begin
        redA_d    = dly.portA[0];
        greenA_d  = dly.portA[1];
        blueA_d   = dly.portA[2];
        redB_d    = dly.portB[0];
        greenB_d  = dly.portB[1];
        blueB_d   = dly.portB[2];
        portAOe_d = powerUpS;
        portBOe_d = powerUpS & splitS;
        strobe_d  = dly.strobe & powerUpS;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            redA               <= `PIX_DATA_RST;
            greenA             <= `PIX_DATA_RST;
            blueA              <= `PIX_DATA_RST;
            redB               <= `PIX_DATA_RST;
            greenB             <= `PIX_DATA_RST;
            blueSecondPortData <= `PIX_DATA_RST;
            portAOe            <= `PIX_BIT_RST;
            portBOe            <= `PIX_BIT_RST;
            outputStrobeClock  <= `PIX_BIT_RST;
            outputStrobeClockN <= ~`PIX_BIT_RST;
            strobeOe           <= `PIX_BIT_RST;
            lineSyncOut        <= `PIX_BIT_RST;
            lineSyncOe         <= `PIX_BIT_RST;
            greenSyncSliceOut  <= `PIX_BIT_RST;
        end else begin
            redA               <= redA_d;
            greenA             <= greenA_d;
            blueA              <= blueA_d;
            redB               <= redB_d;
            greenB             <= greenB_d;
            blueSecondPortData <= blueB_d;
            portAOe            <= portAOe_d;
            portBOe            <= portBOe_d;
            outputStrobeClock  <= strobe_d;
            outputStrobeClockN <= ~strobe_d;
            strobeOe           <= portAOe_d;
            lineSyncOut        <= dly.lineSync;
            lineSyncOe         <= portAOe_d;
            greenSyncSliceOut  <= greenSyncS;
        end
    end

endmodule : rgb_pixel_output_formatter

`default_nettype wire
